/* File: wcm_watchdog.sv */
/*
  watchdog with two personalities (legacy keyed, alternate 18-bit) and a
  clock monitor, with a byte-wide register port and reset pin drive.
  assumes reset_n is the power-on reset of this block, all inputs are
  synchronous to ref_clk, and an analog detector flags slow or absent clock.
*/
`timescale 1ns/10ps
//
// Contract
// - key writes in order; other accesses may come between them.
// - expiry of either watchdog raises a full system reset.
// - service key is write-only; reading it returns zero, no effect.
// - reset flag set by watchdog or monitor reset, cleared by control read; code does not set it for a monitor reset caused by stop alone.
// - clock monitor enable readable always, writable only once.
// - enable and timeout select written together once per reset, reset clears.
// - legacy timeout is clock over 2^15 times 1, 4, 16 or 64.
// - control bits 7 to 5 always read zero.
// - legacy starts by software enable; alternate by option bit.
// - alternate watchdog is an 18-bit counter on the bus clock.
// - alternate: writing zero to clear-port bit 0 restarts the count.
// - reading the clear port returns the port-b interrupt option byte.
// - both personalities keep counting in wait mode.
// - stop entry clears the watchdog counter.
// - stop exit by reset clears after 4064 cycles; by interrupt keeps count.
// - enabled clock monitor resets on slow or absent clock, including stop.
// - monitor drives reset pin four cycles if slow, until recovery if absent; code drives the pin only in the legacy personality.
// - alternate stop-disable option activates the monitor so stop resets.
// - legacy: watchdog, monitor or power-on reset drive the reset pin low.
module wcm_watchdog (
  // clock and reset
  input  wire logic                     ref_clk,
  input  wire logic                     reset_n,
  // register port
  input  wire logic [wcm_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [wcm_pkg::DATA_W-1:0] reg_wdata,
  input  wire logic                     reg_wr,
  input  wire logic                     reg_rd,
  output logic      [wcm_pkg::DATA_W-1:0] reg_rdata,
  // personality and nonvolatile options
  input  wire logic                     alternate_personality,
  input  wire logic                     alt_watchdog_option_enable,
  input  wire logic                     stop_disable_option,
  input  wire logic [wcm_pkg::DATA_W-1:0] portb_interrupt_option,
  // low-power events from the core
  input  wire logic                     stop_enter,
  input  wire logic                     stop_wake_irq,
  input  wire logic                     stop_wake_reset,
  // clock detector and power-on status
  input  wire logic                     clk_slow_detect,
  input  wire logic                     clk_absent_detect,
  input  wire logic                     por_active,
  // reset pin, open drain
  input  wire logic                     reset_pin_in,
  output logic                          reset_pin_out,
  output logic                          reset_pin_oe,
  // system reset request
  output logic                          sys_reset_req
);
  import wcm_pkg::*;

  //////////////////////////////////////////////////////////////////////////
  // declarations
  logic                  enable_r;
  logic [1:0]            sel_r;
  logic                  ctl_once_r;
  logic                  cme_r;
  logic                  cme_once_r;
  logic                  flag_r;
  logic                  key_armed_r;
  logic [PULSE_W-1:0]    pulse_cnt_r;
  logic                  absent_hold_r;
  logic                  slow_prev_r;
  logic                  drive_r;
  logic [STAB_W-1:0]     stab_cnt_r;
  wcm_stop_e             stop_r;
  wcm_stop_e             stop_nxt;
  logic [CNT_W-1:0]      count;
  logic                  expired;
  logic                  any_reset;
  logic                  monitor_on;
  logic                  wr_key;
  logic                  wr_ctl;
  logic                  wr_clr;
  logic                  rd_ctl;
  logic                  key_done;
  logic                  alt_clear;
  logic                  stab_done;
  logic                  cnt_clear;
  logic                  cnt_run;
  logic                  slow_rise;
  logic                  fire_pulse;

  //////////////////////////////////////////////////////////////////////////
  // timeout limit, minus one, for the active personality
  function automatic logic [CNT_W-1:0] wcm_limit(input logic alt, input logic [1:0] sel);
    logic [CNT_W-1:0] lim;
    lim = '0;
    if (alt) begin
      lim = CNT_W'((22'h1 << ALT_BITS) - 22'h1);
    end else begin
      case (sel)
        2'b00:   lim = CNT_W'((22'h1 << PRESCALE_BITS) - 22'h1);
        2'b01:   lim = CNT_W'((22'h1 << (PRESCALE_BITS + 2)) - 22'h1);
        2'b10:   lim = CNT_W'((22'h1 << (PRESCALE_BITS + 4)) - 22'h1);
        default: lim = CNT_W'((22'h1 << (PRESCALE_BITS + 6)) - 22'h1);
      endcase
    end
    return lim;
  endfunction : wcm_limit

  //////////////////////////////////////////////////////////////////////////
  // address decode
  always_comb begin
    wr_key = 1'b0;
    wr_ctl = 1'b0;
    wr_clr = 1'b0;
    rd_ctl = 1'b0;
    if (reg_addr == OFS_SERVICE_KEY) begin
      wr_key = reg_wr;
    end else if (reg_addr == OFS_CONTROL) begin
      wr_ctl = reg_wr;
      rd_ctl = reg_rd;
    end else if (reg_addr == OFS_CLEAR_PORT) begin
      wr_clr = reg_wr;
    end
  end

  // any reset of the system, from us or from the pin
  assign any_reset  = sys_reset_req || !reset_pin_in;
  assign monitor_on = alternate_personality ? stop_disable_option : cme_r;

  //////////////////////////////////////////////////////////////////////////
  // service key sequence; stray values neither arm nor disarm
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      key_armed_r <= 1'b0;
    end else if (any_reset) begin
      key_armed_r <= 1'b0;
    end else if (wr_key && reg_wdata == KEY_FIRST) begin
      key_armed_r <= 1'b1;
    end else if (key_done) begin
      key_armed_r <= 1'b0;
    end
  end

  assign key_done  = wr_key && key_armed_r && (reg_wdata == KEY_SECOND);
  assign alt_clear = wr_clr && alternate_personality && !reg_wdata[ALT_CLEAR_BIT];

  //////////////////////////////////////////////////////////////////////////
  // write-once control fields; any system reset re-opens them
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      enable_r   <= CTL_RESET_VAL[CTL_ENABLE_BIT];
      sel_r      <= CTL_RESET_VAL[CTL_SEL_HI_BIT:CTL_SEL_LO_BIT];
      ctl_once_r <= 1'b0;
    end else if (any_reset) begin
      enable_r   <= CTL_RESET_VAL[CTL_ENABLE_BIT];
      sel_r      <= CTL_RESET_VAL[CTL_SEL_HI_BIT:CTL_SEL_LO_BIT];
      ctl_once_r <= 1'b0;
    end else if (wr_ctl && !ctl_once_r) begin
      enable_r   <= reg_wdata[CTL_ENABLE_BIT];
      sel_r      <= reg_wdata[CTL_SEL_HI_BIT:CTL_SEL_LO_BIT];
      ctl_once_r <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      cme_r      <= CTL_RESET_VAL[CTL_CME_BIT];
      cme_once_r <= 1'b0;
    end else if (any_reset) begin
      cme_r      <= CTL_RESET_VAL[CTL_CME_BIT];
      cme_once_r <= 1'b0;
    end else if (wr_ctl && !cme_once_r) begin
      cme_r      <= reg_wdata[CTL_CME_BIT];
      cme_once_r <= 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // reset cause flag; set wins over the clearing read
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      flag_r <= CTL_RESET_VAL[CTL_FLAG_BIT];
    end else if (fire_pulse || (monitor_on && clk_absent_detect)) begin
      flag_r <= 1'b1;
    end else if (rd_ctl) begin
      flag_r <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // read data, one cycle after the strobe
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      reg_rdata <= READ_ZERO;
    end else if (!reg_rd) begin
      reg_rdata <= READ_ZERO;
    end else if (reg_addr == OFS_CONTROL) begin
      reg_rdata <= {3'h0, flag_r, cme_r, enable_r, sel_r};
    end else if (reg_addr == OFS_CLEAR_PORT) begin
      reg_rdata <= portb_interrupt_option;
    end else begin
      reg_rdata <= READ_ZERO;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // stop handling; clocks are held while stopped, stabilisation counts
  always_comb begin
    stop_nxt = stop_r;
    case (stop_r)
      WCM_RUN: begin
        if (stop_enter) begin
          stop_nxt = WCM_STOPPED;
        end
      end
      WCM_STOPPED: begin
        if (stop_wake_reset) begin
          stop_nxt = WCM_STAB_RST;
        end else if (stop_wake_irq) begin
          stop_nxt = WCM_STAB_IRQ;
        end
      end
      default: begin
        if (stab_done) begin
          stop_nxt = WCM_RUN;
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      stop_r <= WCM_RUN;
    end else begin
      stop_r <= stop_nxt;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      stab_cnt_r <= '0;
    end else if (stop_r == WCM_STAB_RST || stop_r == WCM_STAB_IRQ) begin
      stab_cnt_r <= stab_cnt_r + 1'b1;
    end else begin
      stab_cnt_r <= '0;
    end
  end

  assign stab_done = (stop_r == WCM_STAB_RST || stop_r == WCM_STAB_IRQ)
                     && (stab_cnt_r == STAB_W'(STAB_CYC - 1));

  //////////////////////////////////////////////////////////////////////////
  // timeout counter; wait mode does not gate it
  assign cnt_clear = any_reset
                     || key_done || alt_clear
                     || stop_enter
                     || (stab_done && stop_r == WCM_STAB_RST);
  assign cnt_run   = (alternate_personality ? alt_watchdog_option_enable : enable_r)
                     && (stop_r != WCM_STOPPED);

  wcm_counter u_counter (
    .ref_clk  (ref_clk),
    .reset_n  (reset_n),
    .clear    (cnt_clear),
    .run      (cnt_run),
    .limit_m1 (wcm_limit(alternate_personality, sel_r)),
    .count    (count),
    .expired  (expired)
  );

  //////////////////////////////////////////////////////////////////////////
  // reset generation: fixed pulse for expiry or slow clock, held for absence
  assign slow_rise  = clk_slow_detect && !slow_prev_r;
  assign fire_pulse = expired || (monitor_on && slow_rise);

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      slow_prev_r <= 1'b0;
    end else begin
      slow_prev_r <= clk_slow_detect;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      pulse_cnt_r <= '0;
    end else if (fire_pulse) begin
      pulse_cnt_r <= PULSE_W'(RST_PULSE_CYC);
    end else if (pulse_cnt_r != '0) begin
      pulse_cnt_r <= pulse_cnt_r - 1'b1;
    end
  end

  // a stopped clock counts as absent, so stop with the monitor on resets;
  // the hold keeps itself, since the reset it raises also clears cme
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      absent_hold_r <= 1'b0;
    end else begin
      absent_hold_r <= (monitor_on || absent_hold_r)
                       && (clk_absent_detect || stop_r == WCM_STOPPED);
    end
  end

  assign sys_reset_req = (pulse_cnt_r != '0) || absent_hold_r;

  // alternate personality treats the pin as input only
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      drive_r <= 1'b0;
    end else begin
      drive_r <= !alternate_personality && (sys_reset_req || por_active);
    end
  end

  assign reset_pin_out = 1'b0;
  assign reset_pin_oe  = drive_r;

  //////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  sequence s_key_first;
    wr_key && reg_wdata == KEY_FIRST && !any_reset;
  endsequence

  sequence s_key_second;
    wr_key && reg_wdata == KEY_SECOND && !any_reset && !stop_enter;
  endsequence

  a_key_arms: assert property (
    s_key_first |=> key_armed_r)
    else $error("first key did not arm the service");

  a_key_clears_count: assert property (
    (key_armed_r ##0 s_key_second) |=> (count == '0))
    else $error("key pair did not clear the counter");

  a_stray_no_clear: assert property (
    (wr_key && reg_wdata == KEY_SECOND && !key_armed_r && !any_reset && !stop_enter
      && !alt_clear && cnt_run && count != wcm_limit(alternate_personality, sel_r))
      |=> (count == $past(count) + 1'b1))
    else $error("unarmed second key cleared the counter");

  a_expiry_resets: assert property (
    expired |=> sys_reset_req[*4])
    else $error("expiry did not hold system reset four cycles");

  a_key_read_zero: assert property (
    (reg_rd && reg_addr == OFS_SERVICE_KEY) |=> (reg_rdata == READ_ZERO))
    else $error("service key read returned data");

  a_flag_read_clear: assert property (
    (rd_ctl && !fire_pulse && !(monitor_on && clk_absent_detect)) |=> !flag_r)
    else $error("control read did not clear the flag");

  a_flag_set: assert property (
    expired |=> flag_r)
    else $error("expiry did not set the flag");

  a_cme_once: assert property (
    (wr_ctl && cme_once_r && !any_reset) |=> $stable(cme_r))
    else $error("clock monitor enable changed on second write");

  a_ctl_once: assert property (
    (wr_ctl && ctl_once_r && !any_reset) |=> ($stable(enable_r) && $stable(sel_r)))
    else $error("enable or select changed on second write");

  a_ctl_high_zero: assert property (
    $past(rd_ctl) |-> (reg_rdata[7:5] == 3'h0))
    else $error("unused control bits read nonzero");

  a_clear_port_read: assert property (
    (reg_rd && reg_addr == OFS_CLEAR_PORT) |=> (reg_rdata == $past(portb_interrupt_option)))
    else $error("clear port read did not return option byte");

  a_stop_clears: assert property (
    stop_enter |=> (count == '0))
    else $error("stop entry left the counter running");

  a_stab_length: assert property (
    (stop_r == WCM_STAB_RST && stab_cnt_r != STAB_W'(STAB_CYC - 1))
      |=> (stop_r == WCM_STAB_RST))
    else $error("stabilisation delay ended early");

  a_stab_end: assert property (
    (stop_r == WCM_STAB_RST && stab_cnt_r == STAB_W'(STAB_CYC - 1))
      |=> (stop_r == WCM_RUN && count == '0))
    else $error("reset wake did not clear the counter after the delay");

  a_slow_pulse: assert property (
    (monitor_on && slow_rise && !expired && pulse_cnt_r == '0 && !absent_hold_r
      && !clk_absent_detect && stop_r != WCM_STOPPED)
      |=> sys_reset_req [*4] ##1 (!sys_reset_req || $past(fire_pulse, 1) || absent_hold_r))
    else $error("slow clock reset is not four cycles");

  a_pin_drive: assert property (
    (!alternate_personality && sys_reset_req && !$changed(alternate_personality))
      |=> reset_pin_oe)
    else $error("reset pin not driven in legacy personality");

  a_reset_clears: assert property (
    any_reset |=> (count == '0))
    else $error("system reset left the counter nonzero");

endmodule : wcm_watchdog

/* File: wcm_pkg.sv */
/*
  constants shared by the watchdog with clock monitor: register offsets,
  field positions, key values, reset values and cycle counts.
  assumes an 8-bit register port with a 14-bit byte address and a single
  25 MHz clock.
*/
package wcm_pkg;

  //////////////////////////////////////////////////////////////////////////
  // register port
  localparam int          ADDR_W           = 14;
  localparam int          DATA_W           = 8;
  localparam logic [13:0] OFS_CLEAR_PORT   = 14'h3ff0;
  localparam logic [13:0] OFS_SERVICE_KEY  = 14'h001d;
  localparam logic [13:0] OFS_CONTROL      = 14'h001e;

  //////////////////////////////////////////////////////////////////////////
  // service key values
  localparam logic [7:0]  KEY_FIRST        = 8'h55;
  localparam logic [7:0]  KEY_SECOND       = 8'haa;

  //////////////////////////////////////////////////////////////////////////
  // control register layout, bits 7..5 read as zero
  localparam int          CTL_SEL_LO_BIT   = 0;
  localparam int          CTL_SEL_HI_BIT   = 1;
  localparam int          CTL_ENABLE_BIT   = 2;
  localparam int          CTL_CME_BIT      = 3;
  localparam int          CTL_FLAG_BIT     = 4;
  localparam logic [7:0]  CTL_RESET_VAL    = 8'h00;
  localparam logic [7:0]  READ_ZERO        = 8'h00;
  localparam int          ALT_CLEAR_BIT    = 0;

  //////////////////////////////////////////////////////////////////////////
  // counter geometry
  localparam int          CNT_W            = 21;
  localparam int          PRESCALE_BITS    = 15;
  localparam int          ALT_BITS         = 18;

  //////////////////////////////////////////////////////////////////////////
  // timing, in bus cycles
  localparam int          STAB_CYC         = 4064;
  localparam int          STAB_W           = 12;
  localparam int          RST_PULSE_CYC    = 4;
  localparam int          PULSE_W          = 3;

  //////////////////////////////////////////////////////////////////////////
  // stop handling states
  typedef enum logic [1:0] {
    WCM_RUN,
    WCM_STOPPED,
    WCM_STAB_RST,
    WCM_STAB_IRQ
  } wcm_stop_e;

endpackage : wcm_pkg

/* File: wcm_counter.sv */
/*
  timeout counter of the watchdog: counts while run is high, clears on
  clear, and pulses expired for one cycle when it reaches limit_m1.
  assumes clear and run are synchronous to ref_clk.
*/
`timescale 1ns/10ps
module wcm_counter
  import wcm_pkg::*;
(
  // clock and reset
  input  wire logic                    ref_clk,
  input  wire logic                    reset_n,
  // control
  input  wire logic                    clear,
  input  wire logic                    run,
  input  wire logic [wcm_pkg::CNT_W-1:0] limit_m1,
  // status
  output logic      [wcm_pkg::CNT_W-1:0] count,
  output logic                         expired
);

  //////////////////////////////////////////////////////////////////////////
  // count; clear has priority so a service in the last cycle still saves us
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      count <= '0;
    end else if (clear) begin
      count <= '0;
    end else if (run) begin
      if (count >= limit_m1) begin
        count <= '0;
      end else begin
        count <= count + 1'b1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // one-cycle expiry pulse
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      expired <= 1'b0;
    end else begin
      expired <= run && !clear && (count >= limit_m1);
    end
  end

endmodule : wcm_counter

/* File: tb_top.sv */
/*
  self-checking testbench of the watchdog with clock monitor: register
  access, write-once control, keyed service, stop handling, clock monitor.
  assumes the design package and the watchdog top are compiled first.
*/
`timescale 1ns/10ps
`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin error_cnt++; \
  $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp); end end
module tb_top;
  import wcm_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  logic              ref_clk = 1'b0;
  logic              reset_n = 1'b0;
  logic [ADDR_W-1:0] reg_addr = '0;
  logic [DATA_W-1:0] reg_wdata = '0;
  logic              reg_wr = 1'b0;
  logic              reg_rd = 1'b0;
  logic [DATA_W-1:0] reg_rdata;
  logic              alt_mode = 1'b0;
  logic              stop_enter = 1'b0;
  logic              stop_wake_irq = 1'b0;
  logic              stop_wake_rst = 1'b0;
  logic              alt_en = 1'b0;
  logic              stop_dis = 1'b0;
  logic              clk_slow = 1'b0;
  logic              clk_absent = 1'b0;
  logic              ext_rst_n = 1'b1;
  logic              pin_out;
  logic              pin_oe;
  logic              sys_req;
  logic [DATA_W-1:0] rd_val;
  int                error_cnt = 0;
  int                total_checks = 0;

  // open-drain pin: low while the block or an external source pulls it
  wire               pin_level = ext_rst_n & ~pin_oe;

  always #20 ref_clk = ~ref_clk;

  wcm_watchdog uut (
    .ref_clk                    (ref_clk),
    .reset_n                    (reset_n),
    .reg_addr                   (reg_addr),
    .reg_wdata                  (reg_wdata),
    .reg_wr                     (reg_wr),
    .reg_rd                     (reg_rd),
    .reg_rdata                  (reg_rdata),
    .alternate_personality      (alt_mode),
    .alt_watchdog_option_enable (alt_en),
    .stop_disable_option        (stop_dis),
    .portb_interrupt_option     (8'h5a),
    .stop_enter                 (stop_enter),
    .stop_wake_irq              (stop_wake_irq),
    .stop_wake_reset            (stop_wake_rst),
    .clk_slow_detect            (clk_slow),
    .clk_absent_detect          (clk_absent),
    .por_active                 (1'b0),
    .reset_pin_in               (pin_level),
    .reset_pin_out              (pin_out),
    .reset_pin_oe               (pin_oe),
    .sys_reset_req              (sys_req)
  );

  ////////////////////////////////////////////////////////////////////////////
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge ref_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr    <= 1'b0;
  endtask : wr

  task automatic rd(input logic [ADDR_W-1:0] a);
    @(posedge ref_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd   <= 1'b0;
    #1 rd_val = reg_rdata;
  endtask : rd

  task automatic reset_dut();
    @(posedge ref_clk);
    reset_n <= 1'b0;
    repeat (5) @(posedge ref_clk);
    reset_n <= 1'b1;
  endtask : reset_dut

  // sys_req must stay low for n cycles
  task automatic quiet(input int n);
    logic seen;
    seen = 1'b0;
    repeat (n) begin
      @(posedge ref_clk);
      seen |= sys_req;
    end
    `CHK(seen, 1'b0)
  endtask : quiet

  // waits a bounded time for a reset pulse, checks its length and pin drive
  task automatic expect_reset(input int n, input int len);
    int w;
    int h;
    logic oe_seen;
    w = 0;
    h = 0;
    oe_seen = 1'b0;
    while (sys_req !== 1'b1 && w < n) begin
      @(posedge ref_clk);
      #1 w++;
    end
    `CHK(sys_req, 1'b1)
    while (sys_req === 1'b1 && h < 50) begin
      @(posedge ref_clk);
      #1 h++;
      oe_seen |= pin_oe;
    end
    if (len > 0) `CHK(h, len)
    `CHK(oe_seen, 1'b1)
    repeat (4) @(posedge ref_clk);
  endtask : expect_reset

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset_values();
    rd(OFS_CONTROL);
    `CHK(rd_val, CTL_RESET_VAL)
    rd(OFS_SERVICE_KEY);
    `CHK(rd_val, READ_ZERO)
    alt_mode <= 1'b1;
    rd(OFS_CLEAR_PORT);
    `CHK(rd_val, 8'h5a)
    alt_mode <= 1'b0;
  endtask : t_reset_values

  task automatic t_write_once();
    wr(OFS_CONTROL, 8'hff);
    rd(OFS_CONTROL);
    `CHK(rd_val, 8'h0f)
    wr(OFS_CONTROL, 8'h00);
    rd(OFS_CONTROL);
    `CHK(rd_val, 8'h0f)
    reset_dut();
    rd(OFS_CONTROL);
    `CHK(rd_val, 8'h00)
  endtask : t_write_once

  // legacy select 00: service, stop, then a full 2^15 timeout
  task automatic t_service_stop();
    wr(OFS_CONTROL, 8'h04);
    quiet(20000);
    wr(OFS_SERVICE_KEY, KEY_SECOND);
    wr(OFS_SERVICE_KEY, KEY_FIRST);
    rd(OFS_SERVICE_KEY);
    wr(OFS_SERVICE_KEY, 8'h12);
    rd(OFS_CONTROL);
    `CHK(rd_val, 8'h04)
    wr(OFS_SERVICE_KEY, KEY_SECOND);
    quiet(10000);
    @(posedge ref_clk);
    stop_enter <= 1'b1;
    @(posedge ref_clk);
    stop_enter <= 1'b0;
    repeat (100) @(posedge ref_clk);
    stop_wake_irq <= 1'b1;
    @(posedge ref_clk);
    stop_wake_irq <= 1'b0;
    quiet(32700);
    expect_reset(200, RST_PULSE_CYC);
    rd(OFS_CONTROL);
    `CHK(rd_val, 8'h10)
    rd(OFS_CONTROL);
    `CHK(rd_val, 8'h00)
  endtask : t_service_stop

  task automatic t_monitor();
    @(posedge ref_clk);
    clk_slow <= 1'b1;
    @(posedge ref_clk);
    clk_slow <= 1'b0;
    quiet(20);
    wr(OFS_CONTROL, 8'h08);
    @(posedge ref_clk);
    clk_slow <= 1'b1;
    expect_reset(20, RST_PULSE_CYC);
    clk_slow <= 1'b0;
    rd(OFS_CONTROL);
    `CHK(rd_val, 8'h10)
    wr(OFS_CONTROL, 8'h08);
    @(posedge ref_clk);
    clk_absent <= 1'b1;
    repeat (10) @(posedge ref_clk);
    #1 `CHK(sys_req, 1'b1)
    clk_absent <= 1'b0;
    repeat (20) @(posedge ref_clk);
    #1 `CHK(sys_req, 1'b0)
  endtask : t_monitor

  // alternate personality: clear port, reset wake, stop-disable option
  task automatic t_alternate();
    alt_mode <= 1'b1;
    alt_en   <= 1'b1;
    repeat (50) @(posedge ref_clk);
    wr(OFS_CLEAR_PORT, 8'h01);
    #1 `CHK(uut.count == '0, 1'b0)
    wr(OFS_CLEAR_PORT, 8'hfe);
    #1 `CHK(uut.count, 21'h0)
    @(posedge ref_clk);
    stop_enter <= 1'b1;
    @(posedge ref_clk);
    stop_enter <= 1'b0;
    repeat (20) @(posedge ref_clk);
    stop_wake_rst <= 1'b1;
    @(posedge ref_clk);
    stop_wake_rst <= 1'b0;
    repeat (4080) @(posedge ref_clk);
    #1 `CHK(uut.count < 21'd100, 1'b1)
    stop_dis <= 1'b1;
    @(posedge ref_clk);
    stop_enter <= 1'b1;
    @(posedge ref_clk);
    stop_enter <= 1'b0;
    repeat (5) @(posedge ref_clk);
    #1 `CHK(sys_req, 1'b1)
    @(posedge ref_clk);
    stop_wake_irq <= 1'b1;
    @(posedge ref_clk);
    stop_wake_irq <= 1'b0;
    repeat (3) @(posedge ref_clk);
    #1 `CHK(sys_req, 1'b0)
    stop_dis <= 1'b0;
    alt_en   <= 1'b0;
    alt_mode <= 1'b0;
  endtask : t_alternate

  ////////////////////////////////////////////////////////////////////////////
  task automatic print_verdict();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : print_verdict

  initial begin
    repeat (5) @(posedge ref_clk);
    reset_n <= 1'b1;
    t_reset_values();
    t_write_once();
    t_service_stop();
    t_monitor();
    t_alternate();
    print_verdict();
  end

  // the run needs about 67k cycles; a hang ends it well after that
  initial begin
    repeat (80000) @(posedge ref_clk);
    error_cnt++;
    print_verdict();
  end

endmodule : tb_top
